// >>> hdl/flp_bus_if.sv
// parallel flash bus between the host controller and the partition device
// assumes both ends run on the same clock; dq resolved here from the enables
`timescale 1ns/1ps
`include "flp_regs.svh"

interface flp_bus_if;
	logic               ce_n;     // chip select, low active
	logic               oe_n;     // output enable, low active
	logic               we_n;     // write enable, low active
	logic [`FLP_AW-1:0] addr;     // word address
	logic [15:0]        dq_h;     // host data out
	logic               dq_h_oe;  // host drives dq
	logic [15:0]        dq_d;     // device data out
	logic               dq_d_oe;  // device drives dq
	logic [15:0]        dq;       // resolved bus level

	// undriven bus reads as all ones, like a pulled-up line
	assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 16'hFFFF);

	modport device (
		input  ce_n, oe_n, we_n, addr, dq,
		output dq_d, dq_d_oe
	);
	modport host (
		input  dq,
		output ce_n, oe_n, we_n, addr, dq_h, dq_h_oe
	);
endinterface

// >>> hdl/flp_device.sv
// partition read-state selection of a multi-partition flash device
// assumes pins synchronous to CLK; write algorithms live outside and
// report busy, flags and lock bits on the user side
//
// What this block does
// - FFh to a partition selects array reads
// - reset puts every partition in array mode
// - array reads need no repeated FFh
// - array reads of busy partition give invalid
// - FFh after suspend selects array mode
// - array command ignores program supply level
// - 90h maps identifier space over partition
// - identifier command works while partition busy
// - maker at offset 00h, part at 01h
// - block base plus 02h gives lock bits
// - config at 05h, otp lock 80h, otp 81h-88h
// - query command returns query database fields
// - query command works while partition busy
// - 70h or write sequences select status mode
// - status reads repeat until another command
// - status mode takes single reads only
// - status captured at access start edge
// - status entry leaves other partitions alone
// - status on low byte, high byte zero
// - bits 6:0 per partition, bit 7 shared
// - bit 0 reports other partition activity
// - bits 6:1 carry partition error flags
// - bit 7 one means write engine ready
// - bit 0 set only when another partition busy
`timescale 1ns/1ps
`include "flp_regs.svh"

module flp_device #(
	parameter logic [15:0] MAKER_CODE = 16'h00A5,  // arbitrary value
	parameter logic [15:0] PART_CODE  = 16'h5A01   // arbitrary value
) (
	input  wire logic                        CLK,         // 100 MHz clock
	input  wire logic                        RST,         // async reset, high
	flp_bus_if.device                        bus,         // flash bus pins
	output logic [`FLP_AW-1:0]               ARRAY_ADDR,  // array and query address
	input  wire logic [15:0]                 ARRAY_DATA,  // array word at ARRAY_ADDR
	input  wire logic [15:0]                 QUERY_DATA,  // query word at ARRAY_ADDR
	input  wire logic [`FLP_NPART-1:0]       PART_BUSY,   // partition programming/erasing
	input  wire logic [6*`FLP_NPART-1:0]     PART_FLAGS,  // per-partition status bits 6:1
	input  wire logic [2*`FLP_NBLK-1:0]      BLOCK_LOCK,  // {lockdown, lock} per block
	input  wire logic [15:0]                 CONFIG_WORD, // read configuration contents
	input  wire logic [15:0]                 OTP_LOCK,    // otp lock word
	input  wire logic [127:0]                OTP_DATA,    // otp contents, word 0 low
	output logic                             CMD_VALID,   // command write, one pulse
	output logic [7:0]                       CMD_CODE,    // low byte of written data
	output logic [`FLP_AW-1:0]               CMD_ADDR,    // address of the write
	output logic [15:0]                      CMD_DATA,    // whole written word
	output logic                             CMD_SECOND,  // confirm or data cycle
	output flp_pkg::flp_mode_t [`FLP_NPART-1:0] PART_MODE // read state per partition
);

	flp_pkg::flp_dev_state_t s;
	flp_pkg::flp_dev_state_t next_s;

	logic                   acc;
	logic                   wr_edge;
	logic [1:0]             wpart;
	logic [1:0]             rpart;
	logic [17:0]            poff;
	logic [4:0]             bidx;
	logic [2:0]             oidx;
	logic                   ready;
	logic [7:0]             status_now;
	logic [15:0]            id_word;
	logic [15:0]            word;

	assign acc     = ~bus.ce_n & ~bus.oe_n & bus.we_n;
	// a write is taken when we_n returns high with chip select still low
	assign wr_edge = ~s.we_d & bus.we_n & ~bus.ce_n;
	assign wpart   = bus.addr[`FLP_AW-1:`FLP_PART_LSB];
	assign rpart   = bus.addr[`FLP_AW-1:`FLP_PART_LSB];
	assign poff    = bus.addr[`FLP_PART_LSB-1:0];
	assign bidx    = bus.addr[`FLP_AW-1:`FLP_BLK_LSB];
	assign oidx    = 3'(poff[3:0] - `FLP_OTP_BASE);

	assign ready = ~|PART_BUSY;
	assign status_now = {ready,
	                     PART_FLAGS[6*rpart +: 6],
	                     ~ready & ~PART_BUSY[rpart]};

	always_comb begin
		id_word = `FLP_ZERO_WORD;
		if (bus.addr[`FLP_BLK_LSB-1:0] == `FLP_ID_LOCK) begin
			id_word[1:0] = BLOCK_LOCK[{bidx, 1'b0} +: 2];
		end else if (poff == `FLP_ID_MAKER) begin
			id_word = MAKER_CODE;
		end else if (poff == `FLP_ID_PART) begin
			id_word = PART_CODE;
		end else if (poff == `FLP_ID_CONFIG) begin
			id_word = CONFIG_WORD;
		end else if (poff == `FLP_ID_OTPLOCK) begin
			id_word = OTP_LOCK;
		end else if (poff >= `FLP_ID_OTP_FIRST && poff <= `FLP_ID_OTP_LAST) begin
			id_word = OTP_DATA[{oidx, 4'h0} +: 16];
		end
	end

	always_comb begin
		word = `FLP_ZERO_WORD;
		unique case (s.mode[rpart])
			flp_pkg::MODE_ARRAY: begin
				// array reads in a busy partition are undefined until it finishes
				word = PART_BUSY[rpart] ? `FLP_INVALID_WORD : ARRAY_DATA;
			end
			flp_pkg::MODE_IDENT: begin
				word = id_word;
			end
			flp_pkg::MODE_QUERY: begin
				word = QUERY_DATA;
			end
			flp_pkg::MODE_STATUS: begin
				word = {`FLP_ZERO_BYTE, s.stat_hold};
			end
		endcase
	end

	always_comb begin
		next_s           = s;
		next_s.we_d      = bus.we_n;
		next_s.acc_d     = acc;
		next_s.arr_addr  = bus.addr;
		next_s.cmd_valid = 1'b0;
		// caught once per access so a polling read sees one stable value
		if (acc && !s.acc_d) begin
			next_s.stat_hold = status_now;
		end
		if (wr_edge) begin
			next_s.cmd_valid  = 1'b1;
			next_s.cmd_code   = bus.dq[7:0];
			next_s.cmd_addr   = bus.addr;
			next_s.cmd_data   = bus.dq;
			next_s.cmd_second = s.pending;
			if (s.pending) begin
				// confirm or data cycle; partition stays in status mode
				next_s.pending = 1'b0;
			end else begin
				// only the written partition changes its read state
				unique case (bus.dq[7:0])
					`FLP_CMD_ARRAY: begin
						// taken whatever the supply level, busy or suspended
						next_s.mode[wpart] = flp_pkg::MODE_ARRAY;
					end
					`FLP_CMD_IDENT: begin
						next_s.mode[wpart] = flp_pkg::MODE_IDENT;
					end
					`FLP_CMD_QUERY: begin
						next_s.mode[wpart] = flp_pkg::MODE_QUERY;
					end
					`FLP_CMD_STATUS: begin
						next_s.mode[wpart] = flp_pkg::MODE_STATUS;
					end
					`FLP_CMD_ERASE, `FLP_CMD_PROG, `FLP_CMD_PROG_ALT,
					`FLP_CMD_FASTPROG, `FLP_CMD_LOCK, `FLP_CMD_OTPPROG: begin
						next_s.mode[wpart] = flp_pkg::MODE_STATUS;
						next_s.pending     = 1'b1;
					end
					default: begin
						// clear status, suspend, resume: read states unchanged
						next_s.pending = 1'b0;
					end
				endcase
			end
		end
		// single-word answer per access; burst timing is not modelled
		next_s.dq_out = word;
		next_s.dq_oe  = acc;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			// we_d starts high so the release never looks like a write edge
			s <= '{
				mode:       {`FLP_NPART{flp_pkg::MODE_ARRAY}},
				pending:    1'b0,
				we_d:       1'b1,
				acc_d:      1'b0,
				stat_hold:  `FLP_ZERO_BYTE,
				dq_out:     `FLP_ZERO_WORD,
				dq_oe:      1'b0,
				arr_addr:   '0,
				cmd_valid:  1'b0,
				cmd_code:   `FLP_ZERO_BYTE,
				cmd_addr:   '0,
				cmd_data:   `FLP_ZERO_WORD,
				cmd_second: 1'b0
			};
		end else begin
			s <= next_s;
		end
	end

	assign bus.dq_d    = s.dq_out;
	assign bus.dq_d_oe = s.dq_oe;
	assign ARRAY_ADDR  = s.arr_addr;
	assign CMD_VALID   = s.cmd_valid;
	assign CMD_CODE    = s.cmd_code;
	assign CMD_ADDR    = s.cmd_addr;
	assign CMD_DATA    = s.cmd_data;
	assign CMD_SECOND  = s.cmd_second;
	assign PART_MODE   = s.mode;

endmodule

// >>> hdl/flp_host.sv
// host controller driving single write and read cycles on the flash bus
// assumes software on a plain register port, read data one cycle later
`timescale 1ns/1ps
`include "flp_regs.svh"

module flp_host (
	input  wire logic        CLK,    // 100 MHz clock
	input  wire logic        RST,    // async reset, high
	input  wire logic [7:0]  ADDR,   // register byte address
	input  wire logic [31:0] WDATA,  // register write data
	input  wire logic        WR,     // write strobe
	input  wire logic        RD,     // read strobe
	output logic [31:0]      RDATA,  // read data, cycle after RD
	flp_bus_if.host          bus     // flash bus pins
);

	flp_pkg::flp_host_state_t s;
	flp_pkg::flp_host_state_t next_s;

	logic busy;

	assign busy = (s.phase != flp_pkg::H_IDLE);

	always_comb begin
		next_s       = s;
		next_s.rdata = '0;
		if (RD) begin
			unique case (ADDR)
				`FLP_REG_ADDR:  next_s.rdata = 32'(s.reg_addr);
				`FLP_REG_WDATA: next_s.rdata = 32'(s.reg_wdata);
				`FLP_REG_STAT:  next_s.rdata = 32'(busy);
				`FLP_REG_RDATA: next_s.rdata = 32'(s.last_word);
				default:        next_s.rdata = '0;
			endcase
		end
		if (WR && ADDR == `FLP_REG_ADDR) begin
			next_s.reg_addr = WDATA[`FLP_AW-1:0];
		end
		if (WR && ADDR == `FLP_REG_WDATA) begin
			next_s.reg_wdata = WDATA[15:0];
		end
		unique case (s.phase)
			flp_pkg::H_IDLE: begin
				// a start while busy is dropped; software polls the busy bit
				if (WR && ADDR == `FLP_REG_CTRL && WDATA[`FLP_CTRL_WRITE]) begin
					next_s.phase = flp_pkg::H_WR_SETUP;
					next_s.ce_n  = 1'b0;
					next_s.addr  = s.reg_addr;
					next_s.dq_o  = s.reg_wdata;
					next_s.dq_oe = 1'b1;
				end else if (WR && ADDR == `FLP_REG_CTRL && WDATA[`FLP_CTRL_READ]) begin
					// one word per access, no bursts in any read state
					next_s.phase = flp_pkg::H_RD_WAIT;
					next_s.ce_n  = 1'b0;
					next_s.oe_n  = 1'b0;
					next_s.addr  = s.reg_addr;
					next_s.cnt   = `FLP_READ_CYCLES;
				end
			end
			flp_pkg::H_WR_SETUP: begin
				next_s.phase = flp_pkg::H_WR_PULSE;
				next_s.we_n  = 1'b0;
			end
			flp_pkg::H_WR_PULSE: begin
				next_s.phase = flp_pkg::H_WR_HOLD;
				next_s.we_n  = 1'b1;
			end
			flp_pkg::H_WR_HOLD: begin
				next_s.phase = flp_pkg::H_IDLE;
				next_s.ce_n  = 1'b1;
				next_s.dq_oe = 1'b0;
			end
			flp_pkg::H_RD_WAIT: begin
				next_s.cnt = 3'(s.cnt - 3'h1);
				if (s.cnt == 3'h1) begin
					next_s.last_word = bus.dq;
					next_s.phase     = flp_pkg::H_IDLE;
					next_s.ce_n      = 1'b1;
					next_s.oe_n      = 1'b1;
				end
			end
			default: begin
				next_s.phase = flp_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s <= '{phase: flp_pkg::H_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
			       addr: '0, dq_o: '0, dq_oe: 1'b0, cnt: '0, reg_addr: '0,
			       reg_wdata: '0, last_word: '0, rdata: '0};
		end else begin
			s <= next_s;
		end
	end

	assign bus.ce_n    = s.ce_n;
	assign bus.oe_n    = s.oe_n;
	assign bus.we_n    = s.we_n;
	assign bus.addr    = s.addr;
	assign bus.dq_h    = s.dq_o;
	assign bus.dq_h_oe = s.dq_oe;
	assign RDATA       = s.rdata;

endmodule

// >>> hdl/flp_pkg.sv
// types shared by both ends of the partition read-state link
// assumes flp_regs.svh for partition count and address width
`include "flp_regs.svh"

package flp_pkg;

	typedef enum logic [1:0] {
		MODE_ARRAY,
		MODE_IDENT,
		MODE_QUERY,
		MODE_STATUS
	} flp_mode_t;

	typedef struct packed {
		flp_mode_t [`FLP_NPART-1:0] mode;
		logic                       pending;
		logic                       we_d;
		logic                       acc_d;
		logic [7:0]                 stat_hold;
		logic [15:0]                dq_out;
		logic                       dq_oe;
		logic [`FLP_AW-1:0]         arr_addr;
		logic                       cmd_valid;
		logic [7:0]                 cmd_code;
		logic [`FLP_AW-1:0]         cmd_addr;
		logic [15:0]                cmd_data;
		logic                       cmd_second;
	} flp_dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE,
		H_WR_SETUP,
		H_WR_PULSE,
		H_WR_HOLD,
		H_RD_WAIT
	} flp_host_phase_t;

	typedef struct packed {
		flp_host_phase_t    phase;
		logic               ce_n;
		logic               oe_n;
		logic               we_n;
		logic [`FLP_AW-1:0] addr;
		logic [15:0]        dq_o;
		logic               dq_oe;
		logic [2:0]         cnt;
		logic [`FLP_AW-1:0] reg_addr;
		logic [15:0]        reg_wdata;
		logic [15:0]        last_word;
		logic [31:0]        rdata;
	} flp_host_state_t;

endpackage

// >>> hdl/flp_regs.svh
// constants shared by both ends of the partition read-state link
// assumes a 20-bit word address: 2 partition bits over an 18-bit offset
`ifndef FLP_REGS_SVH
`define FLP_REGS_SVH

`define FLP_NPART        4
`define FLP_AW           20
`define FLP_PART_LSB     18
`define FLP_BLK_LSB      15
`define FLP_NBLK         32

// command codes on the low data byte
`define FLP_CMD_ARRAY    8'hFF
`define FLP_CMD_IDENT    8'h90
`define FLP_CMD_QUERY    8'h98
`define FLP_CMD_STATUS   8'h70
`define FLP_CMD_CLRSTAT  8'h50
`define FLP_CMD_ERASE    8'h20
`define FLP_CMD_PROG     8'h40
`define FLP_CMD_PROG_ALT 8'h10
`define FLP_CMD_FASTPROG 8'h30
`define FLP_CMD_LOCK     8'h60
`define FLP_CMD_OTPPROG  8'hC0

// identifier space offsets
`define FLP_ID_MAKER     18'h00000
`define FLP_ID_PART      18'h00001
`define FLP_ID_LOCK      15'h0002
`define FLP_ID_CONFIG    18'h00005
`define FLP_ID_OTPLOCK   18'h00080
`define FLP_ID_OTP_FIRST 18'h00081
`define FLP_ID_OTP_LAST  18'h00088
`define FLP_OTP_BASE     4'h1

`define FLP_INVALID_WORD 16'hFFFF
`define FLP_ZERO_BYTE    8'h00
`define FLP_ZERO_WORD    16'h0000

// host controller registers
`define FLP_REG_ADDR     8'h00
`define FLP_REG_WDATA    8'h04
`define FLP_REG_CTRL     8'h08
`define FLP_REG_STAT     8'h0C
`define FLP_REG_RDATA    8'h10
`define FLP_CTRL_WRITE   0
`define FLP_CTRL_READ    1
`define FLP_READ_CYCLES  3'h4

`endif

// >>> sim/flp_checker.sv
// bus-side checks of the partition read-state link
// assumes the flp_bus_if signals, one clock, reset high
`timescale 1ns/1ps
`include "flp_regs.svh"

module flp_checker (
	input wire logic               CLK,     // link clock
	input wire logic               RST,     // async reset, high
	input wire logic               ce_n,    // chip select
	input wire logic               oe_n,    // output enable
	input wire logic               we_n,    // write enable
	input wire logic [`FLP_AW-1:0] addr,    // word address
	input wire logic               dq_h_oe, // host drives dq
	input wire logic [15:0]        dq_d,    // device data
	input wire logic               dq_d_oe, // device drives dq
	input wire logic [15:0]        dq       // resolved bus
);
	logic [3:0] stat_p;
	logic       second;
	logic       we_q;
	wire  [1:0] prt   = addr[`FLP_AW-1 -: 2];
	wire        taken = we_n && !we_q && !ce_n;
	wire        srd   = dq_d_oe && !oe_n && stat_p[prt];

	// shadow of which partitions sit in status mode; data cycles never decode
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stat_p <= 4'h0;
			second <= 1'b0;
			we_q   <= 1'b1;
		end else begin
			we_q <= we_n;
			if (taken) begin
				second <= 1'b0;
				if (!second) begin
					case (dq[7:0])
						`FLP_CMD_ARRAY, `FLP_CMD_IDENT, `FLP_CMD_QUERY: stat_p[prt] <= 1'b0;
						`FLP_CMD_STATUS: stat_p[prt] <= 1'b1;
						`FLP_CMD_ERASE, `FLP_CMD_PROG, `FLP_CMD_PROG_ALT,
						`FLP_CMD_FASTPROG, `FLP_CMD_LOCK, `FLP_CMD_OTPPROG: begin
							stat_p[prt] <= 1'b1;
							second      <= 1'b1;
						end
						default: ;
					endcase
				end
			end
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	sequence wr_cyc;
		$fell(we_n) ##1 $rose(we_n) ##1 ce_n;
	endsequence
	sequence rd_hold;
		(!oe_n && !ce_n)[*4] ##1 (oe_n && ce_n);
	endsequence

	wr_shape_a: assert property ($fell(ce_n) && oe_n |=> wr_cyc)
		else $error("write cycle malformed");
	rd_single_a: assert property ($fell(oe_n) |-> rd_hold)
		else $error("read access not a single access");
	bus_owner_a: assert property (!(dq_h_oe && dq_d_oe))
		else $error("both ends drive the data bus");
	dev_drive_a: assert property (dq_d_oe == $past(!ce_n && !oe_n && we_n))
		else $error("device drive not one cycle behind the read");
	we_drive_a: assert property (!we_n |-> dq_h_oe && !ce_n && oe_n)
		else $error("write strobe without host data");
	stat_hi_a: assert property (srd && $past(dq_d_oe) |-> dq_d[15:8] == 8'h00)
		else $error("status upper byte not zero");
	stat_hold_a: assert property (srd && $past(dq_d_oe, 2) |-> $stable(dq_d))
		else $error("status changed within one access");
	stat_combo_a: assert property (srd |-> !(dq_d[7] && dq_d[0]))
		else $error("ready with other partition busy");
endmodule

// >>> sim/flp_tb.sv
// self-checking bench: host and device joined by the flash bus
// assumes the host register port and device user side driven here
`timescale 1ns/1ps
`include "flp_regs.svh"

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end

module flp_tb;
	localparam logic [15:0] MAKER = 16'h0042; // arbitrary value
	localparam logic [15:0] PARTC = 16'h4201; // arbitrary value
	localparam logic [47:0] SETUP = 48'h20_40_10_30_60_C0;
	logic                     clk;
	logic                     rst;
	logic [7:0]               adr;
	logic [31:0]              wdat;
	logic                     wr;
	logic                     rd;
	logic [31:0]              rdata;
	logic [19:0]              array_addr;
	logic [15:0]              array_data;
	logic [15:0]              query_data;
	logic [3:0]               busy;
	logic [23:0]              flags;
	logic [63:0]              block_lock;
	logic [15:0]              cfg;
	logic [15:0]              otp_lock;
	logic [127:0]             otp;
	flp_pkg::flp_mode_t [3:0] part_mode;
	logic                     cmd_valid;
	logic [7:0]               cmd_code;
	logic [19:0]              cmd_addr;
	logic [15:0]              cmd_data;
	logic                     cmd_second;
	int                       cmd_count;
	int                       miscompares;
	int                       tests_run;
	int                       cycles;
	int                       p;
	logic [7:0]               m;
	logic [15:0]              w;
	logic [31:0]              r;
	logic [15:0]              e;

	// array and query contents are address patterns, so any wrong word shows
	assign array_data = array_addr[15:0] ^ 16'hA5C3;
	assign query_data = array_addr[15:0] ^ 16'h3C5A;

	function automatic logic [15:0] arr(input logic [19:0] a);
		return a[15:0] ^ 16'hA5C3;
	endfunction
	function automatic logic [15:0] stat(input int q);
		return {8'h00, ~|busy, flags[6*q +: 6], |busy & ~busy[q]};
	endfunction

	flp_bus_if u_flp_bus_if ();
	flp_host u_flp_host (.CLK(clk), .RST(rst), .ADDR(adr), .WDATA(wdat), .WR(wr), .RD(rd),
		.RDATA(rdata), .bus(u_flp_bus_if.host));
	flp_device #(.MAKER_CODE(MAKER), .PART_CODE(PARTC)) u_flp_device (.CLK(clk), .RST(rst),
		.bus(u_flp_bus_if.device), .ARRAY_ADDR(array_addr), .ARRAY_DATA(array_data),
		.QUERY_DATA(query_data), .PART_BUSY(busy), .PART_FLAGS(flags),
		.BLOCK_LOCK(block_lock), .CONFIG_WORD(cfg), .OTP_LOCK(otp_lock), .OTP_DATA(otp),
		.CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_ADDR(cmd_addr),
		.CMD_DATA(cmd_data), .CMD_SECOND(cmd_second),
		.PART_MODE(part_mode));
	flp_checker u_flp_checker (.CLK(clk), .RST(rst), .ce_n(u_flp_bus_if.ce_n),
		.oe_n(u_flp_bus_if.oe_n), .we_n(u_flp_bus_if.we_n), .addr(u_flp_bus_if.addr),
		.dq_h_oe(u_flp_bus_if.dq_h_oe), .dq_d(u_flp_bus_if.dq_d),
		.dq_d_oe(u_flp_bus_if.dq_d_oe), .dq(u_flp_bus_if.dq));

	task automatic complete_run();
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		adr  <= a;
		wdat <= d;
		wr   <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe: taken at that edge
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		adr <= a;
		rd  <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		r = 32'h1;
		while (r[0] !== 1'b0 && n < 40) begin
			reg_rd(8'h0C, r);
			n++;
		end
		if (r[0] !== 1'b0)
			miscompares++;
	endtask
	task automatic bus_wr(input logic [19:0] a, input logic [15:0] d);
		reg_wr(8'h00, {12'h000, a});
		reg_wr(8'h04, {16'h0000, d});
		reg_wr(8'h08, 32'h1);
		wait_idle();
	endtask
	task automatic rd_chk(input logic [19:0] a, input logic [15:0] x, input string nm);
		reg_wr(8'h00, {12'h000, a});
		reg_wr(8'h08, 32'h2);
		wait_idle();
		reg_rd(8'h10, r);
		w = r[15:0];
		`CHK(nm, x, w)
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cmd_valid === 1'b1)
			cmd_count++;
		if (cycles == 8000) begin
			miscompares++;
			complete_run();
		end
	end

	initial begin
		rst = 1'b1;
		adr = 8'h00;
		wdat = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		busy = 4'h0;
		flags = 24'h5A3C96;
		block_lock = 64'h0000_0009_0000_0000;
		cfg = 16'hB4C1;
		otp_lock = 16'h0002;
		otp = 128'h8888_7777_6666_5555_4444_3333_2222_1111;
		miscompares = 0;
		tests_run = 0;
		cycles = 0;
		cmd_count = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("modes", 8'h00, part_mode)
		rd_chk(20'h40123, arr(20'h40123), "array");
		busy <= 4'h4;
		m = 8'h00;
		for (p = 0; p < 4; p++) begin
			bus_wr({p[1:0], 18'h00010}, 16'h0070);
			m[2*p +: 2] = 2'b11;
			`CHK("modes", m, part_mode)
			rd_chk({p[1:0], 18'h00010}, stat(p), "status");
			rd_chk({p[1:0], 18'h0ABCD}, stat(p), "status");
		end
		busy <= 4'h0;
		// expected status must be reckoned after busy has really dropped
		@(posedge clk);
		rd_chk(20'h40010, stat(1), "ready status");
		e = stat(3);
		reg_wr(8'h00, 32'h000C0010);
		reg_wr(8'h08, 32'h2);
		// capture falls on the first of these edges, flags move one edge later
		repeat (2) @(posedge clk);
		flags <= ~flags;
		wait_idle();
		reg_rd(8'h10, r);
		`CHK("held status", e, r[15:0])
		busy <= 4'h4;
		bus_wr(20'h80000, 16'h0090);
		rd_chk(20'h80000, MAKER, "maker");
		rd_chk(20'h80001, PARTC, "part");
		rd_chk(20'h80005, cfg, "config");
		rd_chk(20'h80080, otp_lock, "otp lock");
		for (p = 0; p < 8; p++)
			rd_chk(20'h80081 + 20'(p), otp[16*p +: 16], "otp");
		rd_chk(20'h88002, 16'h0002, "lock bits");
		rd_chk(20'h80002, 16'h0001, "lock bits");
		bus_wr(20'h80000, 16'h0098);
		rd_chk(20'h80027, 16'h0027 ^ 16'h3C5A, "query");
		bus_wr(20'h80000, 16'h00FF);
		rd_chk(20'h80123, 16'hFFFF, "busy array");
		busy <= 4'h0;
		rd_chk(20'h80123, arr(20'h80123), "array");
		for (p = 0; p < 6; p++) begin
			bus_wr(20'h00100, {8'h00, SETUP[8*p +: 8]});
			bus_wr(20'h00100, 16'h00FF);
			`CHK("setup mode", flp_pkg::MODE_STATUS, part_mode[0])
			`CHK("second cycle", 1'b1, cmd_second)
			`CHK("cmd data", 16'h00FF, cmd_data)
			bus_wr(20'h00100, 16'h00FF);
		end
		bus_wr(20'hC0040, 16'h00FF);
		bus_wr(20'hC0040, 16'h0040);
		bus_wr(20'hC0040, 16'h1234);
		`CHK("cmd code", 8'h34, cmd_code)
		`CHK("cmd addr", 20'hC0040, cmd_addr)
		rd_chk(20'hC0040, stat(3), "auto status");
		bus_wr(20'hC0040, 16'h00B0);
		bus_wr(20'hC0040, 16'h00FF);
		rd_chk(20'hC0040, arr(20'hC0040), "array");
		// one pulse per bus write issued above
		`CHK("command writes", 30, cmd_count)
		// partition 1 still sits in status mode here; reset must undo it
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("modes after reset", 8'h00, part_mode)
		rd_chk(20'h40123, arr(20'h40123), "array after reset");
		complete_run();
	end
endmodule
